// >>> rtl/hbsel_dev.sv
// Notes on behaviour
// R1 - Strobe mode: write stored at strobe rise.
// R2 - Direction mode: write pin high reads, low writes.
// R3 - Strobe mode: each select opens its channel.
// R4 - Direction mode: channel-A select is chip select.
// R5 - Direction mode: B and C selects address channel.
// R6 - Strobe mode: A interrupt driven when bit3 set.
// R7 - Direction mode: A pin shared open-drain interrupt.
// R8 - Strobe mode: B-D interrupts follow bit3 too.
// R9 - Direction mode: B-D interrupt pins held low.
// R10 - Interrupt select high drives all outputs always.
// R11 - Interrupt select low: bit3 alone enables outputs.
// R12 - Host keeps interrupt select low in direction mode.
// R13 - Interrupt select defaults low when undriven.
// R14 - Host ties channel-D select high in direction mode.
// R15 - Read strobe fall puts register byte on bus.
// R16 - Three address bits pick channel register.
// R17 - Eight-bit bus driven only during reads.
// R18 - Channel bits 00..11 map channels A..D.
`timescale 1ns/1ps
`include "hbsel_params.svh"
module hbsel_dev #(
  parameter int NUM_CHAN = 4,
  parameter int NUM_REGS = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  hbsel_if.dev             bus,
  input  wire logic [3:0]  chan_irq_req,
  output      logic [3:0]  irq_enable,
  output      logic        wr_pulse,
  output      logic [1:0]  wr_chan,
  output      logic [2:0]  wr_addr,
  output      logic [7:0]  wr_data
);

  // The decode is hard-wired to two channel bits and three address bits,
  // so any other size is refused while the design is built.
  if (NUM_CHAN != 4 || NUM_REGS != 8) begin : g_bad_size
    $error("hbsel_dev serves exactly four channels of eight registers");
  end

  function automatic logic [4:0] reg_index(input logic [1:0] chan, input logic [2:0] addr);
    reg_index = {chan, addr};
  endfunction

  hbsel_pkg::hbsel_dev_state_t state_q;
  hbsel_pkg::hbsel_dev_state_t state_d;

  // Every channel's registers, indexed by channel and address together.
  logic [7:0] regs_q [0:31];
  logic [1:0] chan_q;
  logic [2:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] data_out_q;
  logic       data_oe_q;
  logic [3:0] irq_out_q;
  logic [3:0] irq_oe_q;
  logic [3:0] irq_out_d;
  logic [3:0] irq_oe_d;
  logic       wr_pulse_q;
  logic [3:0] irq_en_q;

  // Decode of both bus styles into one access request, so the datapath behind it is shared.
  // The price is that a mode change in mid-access is not caught; the host changes it only when idle.
  wire        strobe_mode = bus.bus_style_strobe;
  wire [3:0]  sel         = ~bus.chan_select_n;
  // Only one select should be low; if several are, the lowest channel wins.
  wire [1:0]  strobe_chan = sel[0] ? 2'h0 : (sel[1] ? 2'h1 : (sel[2] ? 2'h2 : 2'h3)); // R3
  wire        strobe_acc  = |sel; // R3
  wire        dir_acc     = sel[0]; // R4
  // Channel D select is not looked at here, the host keeps it high.
  wire [1:0]  dir_chan    = {bus.chan_select_n[2], bus.chan_select_n[1]}; // R5 R18 R14
  wire        acc_sel     = strobe_mode ? strobe_acc : dir_acc;
  wire [1:0]  acc_chan    = strobe_mode ? strobe_chan : dir_chan;
  wire        rd_req      = acc_sel & (strobe_mode ? ~bus.read_strobe_n : bus.write_strobe_n); // R2 R15
  wire        wr_req      = acc_sel & ~bus.write_strobe_n; // R1 R2
  wire [4:0]  acc_idx     = reg_index(acc_chan, bus.reg_addr); // R16
  wire [4:0]  wr_idx      = reg_index(chan_q, addr_q);
  // The store waits for the request to drop, which in strobe mode is the rising edge of the strobe;
  // storing any earlier would keep data that the host may still be settling.
  wire        commit      = (state_q == hbsel_pkg::DEV_WR) && !wr_req; // R1

  // Each channel's interrupt enable is one bit of its modem control register.
  wire [3:0]  mcr_en;
  genvar gc;
  generate
    for (gc = 0; gc < 4; gc++) begin : g_en
      assign mcr_en[gc] = regs_q[reg_index(2'(gc), `HBSEL_MCR_IDX)][`HBSEL_MCR_IRQ_EN_BIT]; // R6 R8
    end
  endgenerate

  // Only one access is open at a time; a read that arrives while a write is open
  // waits until the write has been stored.
  always_comb begin
    state_d = state_q;
    case (state_q)
      hbsel_pkg::DEV_IDLE: begin
        if (rd_req) begin
          state_d = hbsel_pkg::DEV_RD;
        end else if (wr_req) begin
          state_d = hbsel_pkg::DEV_WR;
        end
      end
      hbsel_pkg::DEV_RD: begin
        if (!rd_req) begin
          state_d = hbsel_pkg::DEV_IDLE;
        end
      end
      hbsel_pkg::DEV_WR: begin
        if (!wr_req) begin
          state_d = hbsel_pkg::DEV_IDLE;
        end
      end
      default: state_d = hbsel_pkg::DEV_IDLE;
    endcase
  end

  // Interrupt pin drive for both bus styles.
  always_comb begin
    irq_out_d = 4'h0;
    irq_oe_d  = 4'h0;
    if (strobe_mode) begin
      irq_out_d = chan_irq_req; // R6 R8
      irq_oe_d  = bus.irq_always_on_select ? 4'hf : mcr_en; // R10 R11 R13
    end else begin
      // The select input is ignored here; the host holds it low anyway.
      irq_out_d = 4'h0; // R9 R12
      // All channels share one open-drain pin here; the enables play no part.
      irq_oe_d  = {3'h7, |chan_irq_req}; // R7 R9
    end
  end

  // The access state is the only control register; the rest hold bus data, pin drives and user-side outputs.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= hbsel_pkg::DEV_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // The write is latched while the strobe is low and stored on its release, so
  // the last byte seen before the rising edge is the one kept.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_q  <= 2'h0;
      addr_q  <= 3'h0;
      wdata_q <= 8'h00;
    end else if (wr_req && state_q != hbsel_pkg::DEV_RD) begin
      chan_q  <= acc_chan; // R1
      addr_q  <= bus.reg_addr;
      wdata_q <= bus.data_bus; // R17
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 32; i++) begin
        regs_q[i] <= `HBSEL_REG_RST;
      end
    end else if (commit) begin
      regs_q[wr_idx] <= wdata_q; // R1
    end
  end

  // Data is driven from the cycle after the read is seen until the cycle after the read ends.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_out_q <= 8'h00;
      data_oe_q  <= 1'b0;
    end else begin
      data_oe_q <= (state_d == hbsel_pkg::DEV_RD); // R15 R17
      if (state_q == hbsel_pkg::DEV_IDLE && rd_req) begin
        data_out_q <= regs_q[acc_idx]; // R15 R16
      end
    end
  end

  // Interrupt pins leave through a register so they never glitch while the mode,
  // the select or an enable changes; they follow their causes one cycle late.
  // Reset releases every pin, whatever mode the host selects afterwards.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_out_q  <= 4'h0;
      irq_oe_q   <= 4'h0;
      irq_en_q   <= 4'h0;
      wr_pulse_q <= 1'b0;
    end else begin
      irq_out_q  <= irq_out_d;
      irq_oe_q   <= irq_oe_d;
      irq_en_q   <= mcr_en;
      wr_pulse_q <= commit;
    end
  end

  // The stored write stays readable on the user side until the next one.
  assign bus.dev_data_out = data_out_q;
  assign bus.dev_data_oe  = data_oe_q;
  assign bus.irq_out      = irq_out_q;
  assign bus.irq_oe       = irq_oe_q;
  assign irq_enable       = irq_en_q;
  assign wr_pulse         = wr_pulse_q;
  assign wr_chan          = chan_q;
  assign wr_addr          = addr_q;
  assign wr_data          = wdata_q;

endmodule

// >>> rtl/hbsel_host.sv
`timescale 1ns/1ps
`include "hbsel_params.svh"
module hbsel_host (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  hbsel_if.host            bus,
  input  wire logic        strobe_mode,
  input  wire logic        irq_always_on,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [1:0]  cmd_chan,
  input  wire logic [2:0]  cmd_addr,
  input  wire logic [7:0]  cmd_wdata,
  output      logic        cmd_ready,
  output      logic        rsp_valid,
  output      logic [7:0]  rsp_rdata,
  output      logic [3:0]  irq_seen
);

  hbsel_pkg::hbsel_hst_state_t state_q;

  logic [3:0] cnt_q;
  logic       mode_q;
  logic       irq_always_on_select_q;
  logic       write_q;
  logic [1:0] chan_q;
  logic [2:0] addr_q;
  logic [7:0] wdata_q;
  logic       wstb_n_q;
  logic       rstb_n_q;
  logic [3:0] sel_n_q;
  logic       doe_q;
  logic       rsp_q;
  logic [7:0] rdata_q;
  logic [3:0] irq_q;

  wire take      = (state_q == hbsel_pkg::HST_IDLE) && cmd_valid;
  wire last_stb  = (state_q == hbsel_pkg::HST_STROBE) && (cnt_q == `HBSEL_STROBE_CYC - 4'h1);
  wire last_set  = (state_q == hbsel_pkg::HST_SETUP) && (cnt_q == `HBSEL_SETUP_CYC - 4'h1);
  // Select lines while addressed: one low select per channel, or chip select plus channel bits.
  wire [3:0] strobe_sel = ~(4'h1 << cmd_chan); // R3
  wire [3:0] dir_sel    = {1'b1, cmd_chan[1], cmd_chan[0], 1'b1}; // R5 R14 R18
  wire [3:0] irq_act    = mode_q ? bus.irq_pin : {3'h0, ~bus.irq_pin[0]}; // R7

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= hbsel_pkg::HST_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      case (state_q)
        hbsel_pkg::HST_IDLE: begin
          cnt_q <= 4'h0;
          if (take) begin
            state_q <= hbsel_pkg::HST_SETUP;
          end
        end
        hbsel_pkg::HST_SETUP: begin
          cnt_q <= last_set ? 4'h0 : cnt_q + 4'h1;
          if (last_set) begin
            state_q <= hbsel_pkg::HST_STROBE;
          end
        end
        hbsel_pkg::HST_STROBE: begin
          cnt_q <= cnt_q + 4'h1;
          if (last_stb) begin
            state_q <= hbsel_pkg::HST_DONE;
          end
        end
        hbsel_pkg::HST_DONE: state_q <= hbsel_pkg::HST_IDLE;
        default:             state_q <= hbsel_pkg::HST_IDLE;
      endcase
    end
  end

  // Mode and interrupt select change only between transfers.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q   <= 1'b1;
      irq_always_on_select_q <= 1'b0;
    end else if (state_q == hbsel_pkg::HST_IDLE) begin
      mode_q   <= strobe_mode;
      irq_always_on_select_q <= strobe_mode & irq_always_on; // R12
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      write_q <= 1'b0;
      chan_q  <= 2'h0;
      addr_q  <= 3'h0;
      wdata_q <= 8'h00;
      sel_n_q <= 4'hf;
      doe_q   <= 1'b0;
    end else if (take) begin
      write_q <= cmd_write;
      chan_q  <= cmd_chan;
      addr_q  <= cmd_addr; // R16
      wdata_q <= cmd_wdata;
      sel_n_q <= mode_q ? strobe_sel : dir_sel;
      doe_q   <= cmd_write; // R17
    end else if (state_q == hbsel_pkg::HST_DONE) begin
      sel_n_q <= mode_q ? 4'hf : {3'h7, 1'b1} & {1'b1, chan_q, 1'b1}; // R14
      doe_q   <= 1'b0;
    end else if (!mode_q && state_q == hbsel_pkg::HST_SETUP && last_set) begin
      sel_n_q[0] <= 1'b0; // R4
    end else if (!mode_q && last_stb) begin
      sel_n_q[0] <= 1'b1; // R4
    end
  end

  // Strobe mode pulses one strobe; direction mode holds the level for the whole access.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wstb_n_q <= 1'b1;
      rstb_n_q <= 1'b1;
    end else if (!mode_q) begin
      rstb_n_q <= 1'b1;
      wstb_n_q <= (take) ? ~cmd_write : ((state_q == hbsel_pkg::HST_DONE) ? 1'b1 : wstb_n_q); // R2
    end else if (last_set) begin
      wstb_n_q <= ~write_q; // R1
      rstb_n_q <= write_q; // R15
    end else if (last_stb) begin
      wstb_n_q <= 1'b1; // R1
      rstb_n_q <= 1'b1; // R15
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_q   <= 1'b0;
      rdata_q <= 8'h00;
      irq_q   <= 4'h0;
    end else begin
      rsp_q <= last_stb;
      irq_q <= irq_act;
      if (last_stb && !write_q) begin
        rdata_q <= bus.data_bus; // R15
      end
    end
  end

  assign bus.bus_style_strobe = mode_q;
  assign bus.write_strobe_n   = wstb_n_q;
  assign bus.read_strobe_n    = rstb_n_q;
  assign bus.chan_select_n    = sel_n_q;
  assign bus.reg_addr         = addr_q;
  assign bus.host_data_out    = wdata_q;
  assign bus.host_data_oe     = doe_q;
  assign bus.irq_always_on_select_out       = irq_always_on_select_q;
  // Released unless always-on is wanted; the pin's pull-down then gives the low level.
  assign bus.irq_always_on_select_oe        = irq_always_on_select_q; // R13
  assign cmd_ready            = (state_q == hbsel_pkg::HST_IDLE);
  assign rsp_valid            = rsp_q;
  assign rsp_rdata            = rdata_q;
  assign irq_seen             = irq_q;

endmodule

// >>> rtl/hbsel_if.sv
`timescale 1ns/1ps
interface hbsel_if;
  logic       bus_style_strobe;
  logic       write_strobe_n;
  logic       read_strobe_n;
  logic [3:0] chan_select_n;
  logic [2:0] reg_addr;
  logic [7:0] host_data_out;
  logic       host_data_oe;
  logic [7:0] dev_data_out;
  logic       dev_data_oe;
  logic [7:0] data_bus;
  logic       irq_always_on_select_out;
  logic       irq_always_on_select_oe;
  logic       irq_always_on_select;
  logic [3:0] irq_out;
  logic [3:0] irq_oe;
  logic [3:0] irq_pin;

  // Bus holds 8'hff when nobody drives it.
  assign data_bus = host_data_oe ? host_data_out : (dev_data_oe ? dev_data_out : 8'hff);
  // Internal pull-down: undriven select reads low.
  assign irq_always_on_select = irq_always_on_select_oe & irq_always_on_select_out;
  // External pull-ups: a released interrupt pin reads high.
  assign irq_pin = (irq_oe & irq_out) | ~irq_oe;

  modport dev (
    input  bus_style_strobe, write_strobe_n, read_strobe_n, chan_select_n, reg_addr, data_bus,
    input  irq_always_on_select,
    output dev_data_out, dev_data_oe, irq_out, irq_oe
  );

  modport host (
    output bus_style_strobe, write_strobe_n, read_strobe_n, chan_select_n, reg_addr,
    output host_data_out, host_data_oe, irq_always_on_select_out, irq_always_on_select_oe,
    input  data_bus, irq_pin
  );
endinterface

// >>> rtl/hbsel_params.svh
`ifndef HBSEL_PARAMS_SVH
`define HBSEL_PARAMS_SVH

// Register index of the modem control register inside each channel.
`define HBSEL_MCR_IDX          3'h4
// Bit of the modem control register that enables the interrupt pin.
`define HBSEL_MCR_IRQ_EN_BIT   3
// Reset value of every channel register.
`define HBSEL_REG_RST          8'h00
// Host timing in sys_clk cycles: address setup and strobe width.
`define HBSEL_SETUP_CYC        4'h1
`define HBSEL_STROBE_CYC       4'h3

`endif

// >>> rtl/hbsel_pkg.sv
package hbsel_pkg;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,
    DEV_RD   = 3'b010,
    DEV_WR   = 3'b100
  } hbsel_dev_state_t;

  typedef enum logic [3:0] {
    HST_IDLE   = 4'b0001,
    HST_SETUP  = 4'b0010,
    HST_STROBE = 4'b0100,
    HST_DONE   = 4'b1000
  } hbsel_hst_state_t;

endpackage

// >>> verification/hbsel_bench.sv
`timescale 1ns/1ps
`include "hbsel_params.svh"
module hbsel_bench;
  logic       sys_clk;
  logic       rst_b;
  logic [3:0] chan_irq_req;
  logic [3:0] irq_enable;
  logic       wr_pulse;
  logic [1:0] wr_chan;
  logic [2:0] wr_addr;
  logic [7:0] wr_data;
  logic       strobe_mode;
  logic       irq_always_on;
  logic       cmd_valid;
  logic       cmd_write;
  logic [1:0] cmd_chan;
  logic [2:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic       cmd_ready;
  logic       rsp_valid;
  logic [7:0] rsp_rdata;
  logic [3:0] irq_seen;
  int         n_fail;
  int         cmp_count;

  hbsel_if hb ();

  hbsel_dev u_hbsel_dev (.sys_clk(sys_clk), .rst_b(rst_b), .bus(hb.dev), .chan_irq_req(chan_irq_req),
    .irq_enable(irq_enable), .wr_pulse(wr_pulse), .wr_chan(wr_chan), .wr_addr(wr_addr), .wr_data(wr_data));

  hbsel_host u_hbsel_host (.sys_clk(sys_clk), .rst_b(rst_b), .bus(hb.host), .strobe_mode(strobe_mode),
    .irq_always_on(irq_always_on), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_chan(cmd_chan),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .irq_seen(irq_seen));

  hbsel_chk u_hbsel_chk (.sys_clk(sys_clk), .rst_b(rst_b), .bus_style_strobe(hb.bus_style_strobe),
    .write_strobe_n(hb.write_strobe_n), .read_strobe_n(hb.read_strobe_n), .chan_select_n(hb.chan_select_n),
    .dev_data_oe(hb.dev_data_oe), .irq_always_on_select(hb.irq_always_on_select), .irq_out(hb.irq_out),
    .irq_oe(hb.irq_oe));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic xfer(input logic wr, input logic [1:0] ch, input logic [2:0] ad, input logic [7:0] wd,
                      output logic [7:0] rd);
    int i;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_chan  <= ch;
    cmd_addr  <= ad;
    cmd_wdata <= wd;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 20; i++) begin
      #1;
      if (rsp_valid === 1'b1) break;
      @(posedge sys_clk);
    end
    if (i == 20) begin
      n_fail++;
      conclude();
    end
    chk("cmd_ready busy", 8'h00, {7'h0, cmd_ready});
    rd = rsp_rdata;
    // The device stores on the edge after the strobe ends, so give the write time to land.
    if (wr) begin
      @(posedge sys_clk);
      #1;
      chk("wr_pulse", 8'h01, {7'h0, wr_pulse});
      repeat (2) @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic t_reset();
    chk("irq_pin after reset", 8'h0f, {4'h0, hb.irq_pin});
    chk("irq_always_on_select after reset", 8'h00, {7'h0, hb.irq_always_on_select});
  endtask

  task automatic t_strobe_rw();
    logic [7:0] r;
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, 2'(c), 3'(c), 8'h30 + 8'(c * 17), r);
      chk("wr_chan", 8'(c), {6'h0, wr_chan});
      chk("wr_addr", 8'(c), {5'h0, wr_addr});
      chk("wr_data", 8'h30 + 8'(c * 17), wr_data);
    end
    for (int c = 0; c < 4; c++) begin
      xfer(1'b0, 2'(c), 3'(c), 8'h00, r);
      chk("strobe rdata", 8'h30 + 8'(c * 17), r);
    end
  endtask

  task automatic t_irq();
    logic [7:0] r;
    @(posedge sys_clk);
    chan_irq_req <= 4'b0101;
    xfer(1'b1, 2'd1, `HBSEL_MCR_IDX, 8'(1 << `HBSEL_MCR_IRQ_EN_BIT), r);
    xfer(1'b1, 2'd2, `HBSEL_MCR_IDX, 8'(1 << `HBSEL_MCR_IRQ_EN_BIT), r);
    chk("irq_enable", 8'h06, {4'h0, irq_enable});
    chk("irq_pin bit3", 8'h0d, {4'h0, hb.irq_pin});
    chk("irq_seen bit3", 8'h0d, {4'h0, irq_seen});
    @(posedge sys_clk);
    irq_always_on <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("irq_pin always on", 8'h05, {4'h0, hb.irq_pin});
    @(posedge sys_clk);
    irq_always_on <= 1'b0;
    chan_irq_req  <= 4'b0000;
    xfer(1'b1, 2'd1, `HBSEL_MCR_IDX, 8'h00, r);
    chk("irq_pin cleared", 8'h0b, {4'h0, hb.irq_pin});
  endtask

  task automatic t_dir();
    logic [7:0] r;
    @(posedge sys_clk);
    strobe_mode <= 1'b0;
    repeat (4) @(posedge sys_clk);
    xfer(1'b1, 2'd3, 3'd5, 8'hc3, r);
    chk("dir wr_chan", 8'h03, {6'h0, wr_chan});
    chk("dir wr_data", 8'hc3, wr_data);
    xfer(1'b0, 2'd3, 3'd5, 8'h00, r);
    chk("dir rdata", 8'hc3, r);
    xfer(1'b0, 2'd2, 3'd2, 8'h00, r);
    chk("dir cross rdata", 8'h52, r);
    chk("dir irq idle", 8'h01, {4'h0, hb.irq_pin});
    @(posedge sys_clk);
    chan_irq_req <= 4'b1000;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("dir irq shared", 8'h00, {4'h0, hb.irq_pin});
    chk("irq_seen shared", 8'h01, {7'h0, irq_seen[0]});
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    rst_b         = 1'b0;
    strobe_mode   = 1'b1;
    irq_always_on = 1'b0;
    cmd_valid     = 1'b0;
    cmd_write     = 1'b0;
    cmd_chan      = 2'h0;
    cmd_addr      = 3'h0;
    cmd_wdata     = 8'h00;
    chan_irq_req  = 4'h0;
    n_fail        = 0;
    cmp_count     = 0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    t_reset();
    t_strobe_rw();
    t_irq();
    t_dir();
    conclude();
  end
endmodule

// >>> verification/hbsel_chk.sv
`timescale 1ns/1ps
module hbsel_chk (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       bus_style_strobe,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic [3:0] chan_select_n,
  input wire logic       dev_data_oe,
  input wire logic       irq_always_on_select,
  input wire logic [3:0] irq_out,
  input wire logic [3:0] irq_oe
);
  logic dev_req;
  logic dev_rd;

  // Direction style has one chip select; strobe style needs a select and a strobe together.
  assign dev_req = bus_style_strobe ? ((chan_select_n != 4'hf) && !(read_strobe_n && write_strobe_n))
                                    : !chan_select_n[0];
  assign dev_rd  = bus_style_strobe ? ((chan_select_n != 4'hf) && !read_strobe_n)
                                    : (!chan_select_n[0] && write_strobe_n);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence rd_held;
    dev_rd ##1 dev_rd;
  endsequence

  // Four quiet cycles leave room for the store edge and the one-cycle pin register.
  sequence quiet_strobe;
    (bus_style_strobe && !irq_always_on_select && !dev_req) [*4];
  endsequence

  a_rd_drive: assert property (rd_held |-> dev_data_oe)
    else $error("device did not drive the bus during a read");
  a_rd_release: assert property (!dev_req ##1 !dev_req |-> !dev_data_oe)
    else $error("device still drives the bus after the read");
  a_wr_no_drive: assert property (dev_req && !dev_rd |-> !dev_data_oe)
    else $error("device drives the bus during a write");
  a_oe_cause: assert property ($rose(dev_data_oe) |-> $past(dev_rd))
    else $error("bus drive started without a read request");
  a_irq_always_on_select_all_on: assert property ($past(bus_style_strobe) && $past(irq_always_on_select) |-> irq_oe == 4'hf)
    else $error("interrupt select high but a pin is released");
  a_dir_bcd_low: assert property (!$past(bus_style_strobe) |-> irq_oe[3:1] == 3'b111 && irq_out[3:1] == 3'b000)
    else $error("unused interrupt pins not held low");
  a_dir_open_drain: assert property (!$past(bus_style_strobe) |-> irq_out[0] == 1'b0)
    else $error("shared interrupt pin driven high");
  a_bit3_only: assert property (quiet_strobe |-> $stable(irq_oe))
    else $error("interrupt enables changed without a register write");
  a_dir_irq_always_on_select_low: assert property (!bus_style_strobe |-> !irq_always_on_select)
    else $error("interrupt select high in direction mode");
  a_dir_csd_high: assert property (!bus_style_strobe |-> chan_select_n[3])
    else $error("channel D select low in direction mode");
endmodule
